// >>> logic/ccpm_pkg.sv
`default_nettype none

package ccpm_pkg;

  // ----------------------------------------------------------------
  // Register indexes (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] CCPM_POWER_CONTROL_IDX = 8'h87;
  localparam logic [7:0] CCPM_DIV_IDX  = 8'h88;
  localparam logic [7:0] CCPM_AUX_IDX  = 8'h89;
  localparam logic [7:0] CCPM_IEN_IDX  = 8'h8a;
  localparam logic [7:0] CCPM_CFG_IDX  = 8'h8b;
  localparam logic [7:0] CCPM_STAT_IDX = 8'h8c;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PC_SLEEP    = 0;
  localparam int PC_PDOWN    = 1;
  localparam int PC_POWER_UP = 4;
  localparam int PC_BROWNOUT = 5;
  localparam int PC_BAUD_DBL = 7;
  localparam int AUX_BO_IRQ  = 5;
  localparam int AUX_BO_DIS  = 6;
  localparam int IEN_BO      = 5;
  localparam int IEN_GLOBAL  = 7;
  localparam int CFG_HALVE   = 0;
  localparam int CFG_BO_LVL  = 1;
  localparam int CFG_XTAL    = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CCPM_POWER_CONTROL_POR   = 8'h30;
  localparam logic [7:0] CCPM_POWER_CONTROL_KEEP  = 8'h30;
  localparam logic [7:0] CCPM_CFG_RESET  = 8'h06;
  localparam logic [7:0] CCPM_ZERO_BYTE  = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CCPM_MACHINE_TICKS = 6;
  localparam int CCPM_XTAL_CLOCKS   = 1024;
  localparam int CCPM_RC_CLOCKS     = 256;

  // Sense input positions
  localparam int SN_BO25 = 0;
  localparam int SN_BO38 = 1;
  localparam int SN_POR  = 2;
  localparam int SN_WDT  = 3;

  typedef enum logic [1:0] {CCPM_RUN, CCPM_IDLE, CCPM_PDOWN, CCPM_WAKE} ccpm_mode_t;

  typedef struct packed {
    logic wdt_overflow;
    logic power_on_detect;
    logic below_3v8;
    logic below_2v5;
  } ccpm_sense_t;

  typedef struct packed {
    logic cpu_tick;
    logic periph_tick;
    logic machine_tick;
  } ccpm_ticks_t;

endpackage

`default_nettype wire

// >>> logic/ccpm_manager.sv
// Overview of operation
// (R1) Halving option makes machine cycle twelve clocks
// (R2) Divider zero: raw or halved oscillator rate
// (R3) Divider N divides by two times N+1
// (R4) Divider changes apply at once, no stall
// (R5) Brownout resets, or interrupts when select set
// (R6) Level bit picks 2.5 V or 3.8 V
// (R7) Brownout reset held while supply stays low
// (R8) Brownout interrupt fires once per falling crossing
// (R9) Brownout interrupt needs global and own enable
// (R10) Brownout sets sticky flag until software clears
// (R11) Disable bit stops brownout resets and interrupts
// (R12) Power-up detection sets sticky power-up flag
// (R13) Sleep bit idles; interrupt or reset ends it
// (R14) Power-down bit stops oscillator, clears on exit
// (R15) Reset or enabled wake interrupt ends power-down
// (R16) Wake waits 1024 crystal or 256 other clocks
// (R17) Brownout wakes or resets from power-down
// (R18) Watchdog overflow resets even in power-down
// (R19) Brownout and watchdog keep working in power-down
// (R20) Baud doubler bit drives serial port doubling
// (R21) Two user flags are plain storage
`timescale 1ns/1ps
`default_nettype none

module ccpm_manager
#(
  parameter int XTAL_STARTUP_CLOCKS = ccpm_pkg::CCPM_XTAL_CLOCKS,
  parameter int RC_STARTUP_CLOCKS   = ccpm_pkg::CCPM_RC_CLOCKS
)
(
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output var  logic                  hreadyout,
  output var  logic                  hresp,
  output var  logic [31:0]           hrdata,
  input  wire ccpm_pkg::ccpm_sense_t sense,
  input  wire logic                  irq_pending,
  input  wire logic                  wake_irq_pending,
  output var  ccpm_pkg::ccpm_ticks_t ticks,
  output var  logic                  cpu_reset,
  output var  logic                  brownout_irq,
  output var  logic                  osc_enable,
  output var  logic                  baud_doubler
);
  import ccpm_pkg::*;

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  if (XTAL_STARTUP_CLOCKS < 1 || XTAL_STARTUP_CLOCKS > 2047 ||
      RC_STARTUP_CLOCKS < 1 || RC_STARTUP_CLOCKS > 2047)
  begin : g_bad_param
    $error("startup clock counts must lie in 1..2047");
  end

  localparam logic [10:0] XTAL_LAST = 11'(XTAL_STARTUP_CLOCKS - 1);
  localparam logic [10:0] RC_LAST   = 11'(RC_STARTUP_CLOCKS - 1);
  localparam logic [2:0]  MC_LAST   = 3'(CCPM_MACHINE_TICKS - 1);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    ccpm_mode_t  mode;
    logic [7:0]  power_control;
    logic [7:0]  divider;
    logic [7:0]  aux;
    logic [7:0]  ien;
    logic [7:0]  cfg;
    logic [3:0]  sync1;
    logic [3:0]  sync2;
    logic [3:0]  sync3;
    logic [3:0]  filt;
    logic [3:0]  filt_prev;
    logic        bo_prev;
    logic [10:0] div_cnt;
    logic [2:0]  mc_cnt;
    logic [10:0] wake_cnt;
    logic        ahb_wr;
    logic        ahb_hit;
    logic [7:0]  ahb_idx;
    logic [31:0] rdata;
    ccpm_ticks_t tk;
    logic        rst_out;
    logic        bo_irq;
    logic        osc_on;
  } ccpm_state_t;

  ccpm_state_t q;
  ccpm_state_t n;

  logic        bo_sel;
  logic        bo_active;
  logic        bo_reset_lvl;
  logic        bo_rise;
  logic        bo_irq_req;
  logic        wdt_evt;
  logic        por_rise;
  logic        int_reset;
  logic        wake_evt;
  logic        addr_ok;
  logic [7:0]  rd_byte;
  logic [10:0] ratio;
  logic [10:0] wake_last;

  always_comb
  begin
    n = q;

    // --------------------------------------------------------------
    // Sense synchronisers: a change counts when stages two and three agree
    // --------------------------------------------------------------
    n.sync1 = sense;
    n.sync2 = q.sync1;
    n.sync3 = q.sync2;
    for (int i = 0; i < 4; i++)
    begin
      if (q.sync2[i] == q.sync3[i])
      begin
        n.filt[i] = q.sync3[i];
      end
    end
    n.filt_prev = q.filt;

    // Detector and watchdog logic uses no oscillator tick, so it keeps running in power-down
    bo_sel       = q.cfg[CFG_BO_LVL] ? q.filt[SN_BO25] : q.filt[SN_BO38];  // see (R6) (R19)
    bo_active    = bo_sel && !q.aux[AUX_BO_DIS];                           // see (R11)
    bo_reset_lvl = bo_active && !q.aux[AUX_BO_IRQ];                        // see (R5) (R7)
    bo_rise      = bo_active && !q.bo_prev;
    bo_irq_req   = bo_rise && q.aux[AUX_BO_IRQ]
                   && q.ien[IEN_GLOBAL] && q.ien[IEN_BO];                  // see (R8) (R9)
    wdt_evt      = q.filt[SN_WDT] && !q.filt_prev[SN_WDT];                 // see (R18)
    por_rise     = q.filt[SN_POR] && !q.filt_prev[SN_POR];
    int_reset    = bo_reset_lvl || wdt_evt || q.filt[SN_POR];
    wake_evt     = wake_irq_pending || bo_irq_req;                         // see (R15) (R17)
    n.bo_prev    = bo_active;

    // --------------------------------------------------------------
    // Bus data phase: writes land here
    // --------------------------------------------------------------
    if (q.ahb_wr && q.ahb_hit)
    begin
      case (q.ahb_idx)
        CCPM_POWER_CONTROL_IDX: n.power_control    = hwdata[7:0];  // see (R21)
        CCPM_DIV_IDX:  n.divider = hwdata[7:0];  // see (R4)
        CCPM_AUX_IDX:  n.aux     = hwdata[7:0];
        CCPM_IEN_IDX:  n.ien     = hwdata[7:0];
        CCPM_CFG_IDX:  n.cfg     = hwdata[7:0];
        default:       n.power_control    = n.power_control;
      endcase
    end

    // --------------------------------------------------------------
    // Power mode sequencing
    // --------------------------------------------------------------
    wake_last = q.cfg[CFG_XTAL] ? XTAL_LAST : RC_LAST;
    case (q.mode)
      CCPM_RUN:
      begin
        n.wake_cnt = '0;
        if (n.power_control[PC_PDOWN])
        begin
          n.mode = CCPM_PDOWN;                         // see (R14)
        end
        else if (n.power_control[PC_SLEEP])
        begin
          n.mode = CCPM_IDLE;                          // see (R13)
        end
      end
      CCPM_IDLE:
      begin
        if (irq_pending || bo_irq_req)
        begin
          n.mode            = CCPM_RUN;                // see (R13)
          n.power_control[PC_SLEEP]  = 1'b0;
        end
      end
      CCPM_PDOWN:
      begin
        if (wake_evt)
        begin
          n.mode     = CCPM_WAKE;                      // see (R15) (R16)
          n.wake_cnt = '0;
        end
      end
      CCPM_WAKE:
      begin
        if (q.wake_cnt == wake_last)
        begin
          n.mode            = CCPM_RUN;                // see (R16)
          n.power_control[PC_PDOWN]  = 1'b0;                    // see (R14)
          n.power_control[PC_SLEEP]  = 1'b0;
        end
        else
        begin
          n.wake_cnt = q.wake_cnt + 11'd1;
        end
      end
      default: n.mode = CCPM_RUN;
    endcase

    // Internal reset beats any mode and keeps only the cause flags and cfg
    if (int_reset)
    begin
      n.mode    = CCPM_RUN;                            // see (R13) (R15) (R17) (R18)
      n.power_control    = n.power_control & CCPM_POWER_CONTROL_KEEP;
      n.divider = CCPM_ZERO_BYTE;
      n.aux     = CCPM_ZERO_BYTE;
      n.ien     = CCPM_ZERO_BYTE;
    end

    // Hardware sets applied last so a set wins over a same-cycle clear
    if (bo_rise)
    begin
      n.power_control[PC_BROWNOUT] = 1'b1;                      // see (R10)
    end
    if (por_rise)
    begin
      n.power_control[PC_POWER_UP] = 1'b1;                      // see (R12)
    end

    // --------------------------------------------------------------
    // Clock division
    // --------------------------------------------------------------
    if (q.divider == 8'h00)
    begin
      ratio = q.cfg[CFG_HALVE] ? 11'd2 : 11'd1;        // see (R2)
    end
    else
    begin
      ratio = {2'b00, q.divider, 1'b0} + 11'd2;        // see (R3)
      if (q.cfg[CFG_HALVE])
      begin
        ratio = {ratio[9:0], 1'b0};                    // see (R1)
      end
    end

    n.tk = '0;
    if (n.mode == CCPM_PDOWN || n.mode == CCPM_WAKE)
    begin
      n.div_cnt = '0;
    end
    // A counter past a freshly shortened ratio wraps at once instead of stalling
    else if (q.div_cnt >= ratio - 11'd1)
    begin
      n.div_cnt        = '0;                           // see (R4)
      n.tk.periph_tick = 1'b1;
      n.tk.cpu_tick    = (n.mode == CCPM_RUN) && !int_reset;
      if (q.mc_cnt == MC_LAST)
      begin
        n.mc_cnt          = '0;
        n.tk.machine_tick = 1'b1;                      // see (R1)
      end
      else
      begin
        n.mc_cnt = q.mc_cnt + 3'd1;
      end
    end
    else
    begin
      n.div_cnt = q.div_cnt + 11'd1;
    end

    n.rst_out = int_reset;                             // see (R7) (R18)
    n.bo_irq  = bo_irq_req;                            // see (R8)
    n.osc_on  = (n.mode != CCPM_PDOWN);                // see (R14) (R16)

    // --------------------------------------------------------------
    // Bus address phase; read data built from the updated state
    // --------------------------------------------------------------
    addr_ok = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'b00) && (hsize == 3'b010);
    case (haddr[9:2])
      CCPM_POWER_CONTROL_IDX: rd_byte = n.power_control;
      CCPM_DIV_IDX:  rd_byte = n.divider;
      CCPM_AUX_IDX:  rd_byte = n.aux;
      CCPM_IEN_IDX:  rd_byte = n.ien;
      CCPM_CFG_IDX:  rd_byte = n.cfg;
      CCPM_STAT_IDX: rd_byte = {3'b000, int_reset, bo_active, n.osc_on, n.mode};
      default:       rd_byte = CCPM_ZERO_BYTE;
    endcase
    n.ahb_wr = 1'b0;
    if (hsel && htrans[1] && hready)
    begin
      n.ahb_wr  = hwrite;
      n.ahb_hit = addr_ok;
      n.ahb_idx = haddr[9:2];
      n.rdata   = (!hwrite && addr_ok) ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      q         <= '0;
      q.mode    <= CCPM_RUN;
      q.power_control    <= CCPM_POWER_CONTROL_POR;
      q.cfg     <= CCPM_CFG_RESET;
      q.osc_on  <= 1'b1;
      q.rst_out <= 1'b1;
    end
    else
    begin
      q <= n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hreadyout    = 1'b1;
  assign hresp        = 1'b0;
  assign hrdata       = q.rdata;
  assign ticks        = q.tk;
  assign cpu_reset    = q.rst_out;
  assign brownout_irq = q.bo_irq;
  assign osc_enable   = q.osc_on;
  assign baud_doubler = q.power_control[PC_BAUD_DBL];  // see (R20)

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  a_bo_reset_hold: assert property (bo_reset_lvl |=> cpu_reset) // see (R5) (R7)
    else $error("brownout reset not held");
  a_bo_irq_once: assert property (brownout_irq |=> !brownout_irq) // see (R8)
    else $error("brownout interrupt repeated");
  a_bo_irq_gate: assert property (brownout_irq |-> $past(q.ien[IEN_GLOBAL] && q.ien[IEN_BO])) // see (R9)
    else $error("brownout interrupt without enables");
  a_bo_disabled: assert property (q.aux[AUX_BO_DIS] && !wdt_evt && !q.filt[SN_POR] |=> !cpu_reset) // see (R11)
    else $error("disabled brownout caused reset");
  a_bof_sticky: assert property (q.power_control[PC_BROWNOUT] && !(q.ahb_wr && q.ahb_hit) |=> q.power_control[PC_BROWNOUT]) // see (R10)
    else $error("brownout flag dropped");
  a_bof_set: assert property (bo_rise |=> q.power_control[PC_BROWNOUT]) // see (R10)
    else $error("brownout flag not set");
  a_pof_set: assert property (por_rise |=> q.power_control[PC_POWER_UP]) // see (R12)
    else $error("power-up flag not set");
  a_idle_exit: assert property (q.mode == CCPM_IDLE && irq_pending |=> q.mode == CCPM_RUN && !q.power_control[PC_SLEEP]) // see (R13)
    else $error("idle not left on interrupt");
  a_pd_osc_off: assert property (q.mode == CCPM_PDOWN |-> !osc_enable && !ticks.periph_tick) // see (R14)
    else $error("oscillator running in power-down");
  a_wake_rc: assert property ($rose(q.mode == CCPM_WAKE) && !q.cfg[CFG_XTAL] && !int_reset
                              |-> (q.mode == CCPM_WAKE)[*8]) // see (R16)
    else $error("wake delay too short");
  a_wake_done: assert property (q.mode == CCPM_WAKE && q.wake_cnt == wake_last && !int_reset
                                |=> q.mode == CCPM_RUN && !q.power_control[PC_PDOWN]) // see (R16)
    else $error("wake did not finish");
  a_wdt_reset: assert property (wdt_evt |=> cpu_reset) // see (R18)
    else $error("watchdog overflow without reset");
  a_tick_raw: assert property (ticks.periph_tick && q.divider == 8'h00 && !q.cfg[CFG_HALVE]
                               && q.mode != CCPM_PDOWN && n.mode == CCPM_RUN |=> ticks.periph_tick) // see (R2)
    else $error("raw rate tick missing");

  c_idle_exit: cover property (q.mode == CCPM_IDLE ##1 q.mode == CCPM_RUN);
  c_wake_done: cover property (q.mode == CCPM_WAKE ##1 q.mode == CCPM_RUN);
  c_bo_irq:    cover property (brownout_irq);
  c_div_max:   cover property (q.divider == 8'hff && ticks.machine_tick);

endmodule

`default_nettype wire

// >>> verif/ccpm_manager_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) \
  begin \
    checks_done++; \
    if ((g) !== (e)) \
    begin \
      fail_count++; \
      $display("Error %s expected %0h seen %0h", nm, e, g); \
    end \
  end

module ccpm_manager_tb_top;
  import ccpm_pkg::*;

  // Short wake counts keep power-down scenarios quick
  localparam int XT = 16;
  localparam int RC = 9;

  logic        clk;
  logic        reset_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  ccpm_sense_t sense;
  logic        irq_pending;
  logic        wake_irq_pending;
  ccpm_ticks_t ticks;
  logic        cpu_reset;
  logic        brownout_irq;
  logic        osc_enable;
  logic        baud_doubler;
  int          fail_count;
  int          checks_done;
  logic [7:0]  rv;
  int          p;
  int          c_cpu;
  int          c_per;
  int          c_irq;
  int          c_rst;

  ccpm_manager #(.XTAL_STARTUP_CLOCKS(XT), .RC_STARTUP_CLOCKS(RC)) i_dut (
    .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sense(sense),
    .irq_pending(irq_pending), .wake_irq_pending(wake_irq_pending), .ticks(ticks),
    .cpu_reset(cpu_reset), .brownout_irq(brownout_irq), .osc_enable(osc_enable),
    .baud_doubler(baud_doubler));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // A wait that used up its bound ends the run as a failure
  task automatic limit(input string nm, input int k, input int lim);
    if (k >= lim)
    begin
      fail_count++;
      $display("Error %s expected below %0d seen %0d", nm, lim, k);
      close_out();
    end
  endtask

  // Bounded wait for hready high at a rising edge
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        fail_count++;
        $display("Error hready expected 1 seen %b", hreadyout);
        close_out();
      end
      @(posedge clk);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'b00};
    hwrite <= wr;
    hsize  <= 3'b010;
    htrans <= 2'b10;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    wait_ready();
    rd = hrdata[7:0];
    `CHK("hresp", 1'b0, hresp)
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] x;
    bus(1'b1, idx, d, x);
  endtask

  task automatic cnt(input int n);
    c_cpu = 0;
    c_per = 0;
    c_irq = 0;
    c_rst = 0;
    repeat (n)
    begin
      @(posedge clk);
      c_cpu += int'(ticks.cpu_tick === 1'b1);
      c_per += int'(ticks.periph_tick === 1'b1);
      c_irq += int'(brownout_irq === 1'b1);
      c_rst += int'(cpu_reset === 1'b1);
    end
  endtask

  // Second full period of the chosen tick, after any divider change settled
  task automatic period(input bit mach, output int pr);
    int k;
    repeat (2)
    begin
      k = 0;
      do @(posedge clk); while ((mach ? ticks.machine_tick : ticks.periph_tick) !== 1'b1 && ++k < 5000);
      limit("tick_wait", k, 5000);
      k = 0;
      do begin @(posedge clk); k++; end while ((mach ? ticks.machine_tick : ticks.periph_tick) !== 1'b1 && k < 5000);
      limit("tick_period", k, 5000);
    end
    pr = k;
  endtask

  task automatic t_regs();
    bus(1'b0, CCPM_POWER_CONTROL_IDX, 8'h00, rv);
    `CHK("power_control_reset", 8'h30, rv)
    bus(1'b0, CCPM_CFG_IDX, 8'h00, rv);
    `CHK("cfg_reset", 8'h06, rv)
    bus(1'b0, 8'hf0, 8'h00, rv);
    `CHK("unmapped", 8'h00, rv)
    wr(CCPM_POWER_CONTROL_IDX, 8'h8c);
    bus(1'b0, CCPM_POWER_CONTROL_IDX, 8'h00, rv);
    `CHK("power_control_rw", 8'h8c, rv)
    `CHK("baud_on", 1'b1, baud_doubler)
    wr(CCPM_POWER_CONTROL_IDX, 8'h00);
    @(posedge clk);
    `CHK("baud_off", 1'b0, baud_doubler)
    $display("test regs done");
  endtask

  task automatic t_div();
    logic [7:0] dv[5] = '{8'h00, 8'h01, 8'hff, 8'h00, 8'h03};
    logic [7:0] cf[5] = '{8'h06, 8'h06, 8'h06, 8'h07, 8'h07};
    int         ex[5] = '{1, 4, 512, 2, 16};
    for (int i = 0; i < 5; i++)
    begin
      wr(CCPM_CFG_IDX, cf[i]);
      wr(CCPM_DIV_IDX, dv[i]);
      period(1'b0, p);
      `CHK("tick_period", ex[i], p)
      if (dv[i] == 8'h00)
      begin
        period(1'b1, p);
        `CHK("machine_period", 6 * ex[i], p)
      end
    end
    wr(CCPM_CFG_IDX, 8'h06);
    wr(CCPM_DIV_IDX, 8'h00);
    $display("test divider done");
  endtask

  task automatic t_idle();
    wr(CCPM_POWER_CONTROL_IDX, 8'h01);
    cnt(40);
    `CHK("idle_cpu", 0, c_cpu)
    `CHK("idle_periph", 1'b1, c_per > 0)
    irq_pending <= 1'b1;
    repeat (4) @(posedge clk);
    irq_pending <= 1'b0;
    bus(1'b0, CCPM_POWER_CONTROL_IDX, 8'h00, rv);
    `CHK("idle_exit", 8'h00, rv)
    $display("test idle done");
  endtask

  task automatic t_pdown(input logic xtal, input int stc);
    int k;
    wr(CCPM_CFG_IDX, {5'h0, xtal, 2'b10});
    wr(CCPM_POWER_CONTROL_IDX, 8'h02);
    irq_pending <= 1'b1;
    cnt(30);
    `CHK("pd_osc", 1'b0, osc_enable)
    `CHK("pd_idle_irq", 0, c_cpu)
    irq_pending <= 1'b0;
    wake_irq_pending <= 1'b1;
    k = 0;
    do @(posedge clk); while (osc_enable !== 1'b1 && ++k < 50);
    limit("osc_wait", k, 50);
    wake_irq_pending <= 1'b0;
    k = 0;
    do begin @(posedge clk); k++; end while (ticks.cpu_tick !== 1'b1 && k < 2000);
    limit("wake_wait", k, 2000);
    // Oscillator is seen on the second edge after the wake request, the first CPU tick stc edges later
    `CHK("wake_len", stc, k)
    bus(1'b0, CCPM_POWER_CONTROL_IDX, 8'h00, rv);
    `CHK("pd_exit", 8'h00, rv)
    $display("test power-down done");
  endtask

  task automatic t_bo_reset();
    sense.below_3v8 <= 1'b1;
    cnt(15);
    `CHK("bo_level", 0, c_rst)
    sense.below_2v5 <= 1'b1;
    repeat (8) @(posedge clk);
    cnt(30);
    `CHK("bo_hold", 30, c_rst)
    sense <= '0;
    repeat (10) @(posedge clk);
    `CHK("bo_release", 1'b0, cpu_reset)
    bus(1'b0, CCPM_POWER_CONTROL_IDX, 8'h00, rv);
    `CHK("bo_flag", 8'h20, rv)
    wr(CCPM_POWER_CONTROL_IDX, 8'h00);
    $display("test brownout reset done");
  endtask

  task automatic bo_pulse();
    sense.below_3v8 <= 1'b1;
    cnt(40);
    sense.below_3v8 <= 1'b0;
    repeat (10) @(posedge clk);
  endtask

  task automatic t_bo_irq();
    wr(CCPM_CFG_IDX, 8'h04);
    wr(CCPM_AUX_IDX, 8'h20);
    wr(CCPM_IEN_IDX, 8'ha0);
    wr(CCPM_POWER_CONTROL_IDX, 8'h02);
    bo_pulse();
    `CHK("irq_once", 1, c_irq)
    `CHK("irq_no_reset", 0, c_rst)
    `CHK("irq_wake", 1'b1, osc_enable)
    bus(1'b0, CCPM_POWER_CONTROL_IDX, 8'h00, rv);
    `CHK("irq_flag", 8'h20, rv)
    wr(CCPM_POWER_CONTROL_IDX, 8'h00);
    wr(CCPM_IEN_IDX, 8'h20);
    bo_pulse();
    `CHK("irq_global_off", 0, c_irq)
    // The flag is set by detection itself, whether or not the interrupt is taken
    bus(1'b0, CCPM_POWER_CONTROL_IDX, 8'h00, rv);
    `CHK("irq_off_flag", 8'h20, rv)
    wr(CCPM_POWER_CONTROL_IDX, 8'h00);
    wr(CCPM_IEN_IDX, 8'ha0);
    wr(CCPM_AUX_IDX, 8'h60);
    bo_pulse();
    `CHK("dis_irq", 0, c_irq + c_rst)
    bus(1'b0, CCPM_POWER_CONTROL_IDX, 8'h00, rv);
    `CHK("dis_flag", 8'h00, rv)
    wr(CCPM_AUX_IDX, 8'h00);
    wr(CCPM_CFG_IDX, 8'h06);
    $display("test brownout irq done");
  endtask

  task automatic t_wdt_por();
    wr(CCPM_POWER_CONTROL_IDX, 8'h02);
    repeat (4) @(posedge clk);
    sense.wdt_overflow <= 1'b1;
    cnt(20);
    `CHK("wdt_reset", 1, c_rst)
    `CHK("wdt_osc", 1'b1, osc_enable)
    sense.power_on_detect <= 1'b1;
    repeat (8) @(posedge clk);
    sense <= '0;
    repeat (8) @(posedge clk);
    bus(1'b0, CCPM_POWER_CONTROL_IDX, 8'h00, rv);
    `CHK("por_flag", 8'h10, rv)
    $display("test watchdog and power-on done");
  endtask

  initial
  begin
    fail_count = 0;
    checks_done = 0;
    reset_n = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = '0;
    sense = '0;
    irq_pending = 1'b0;
    wake_irq_pending = 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_div();
    t_idle();
    t_pdown(1'b1, XT);
    t_pdown(1'b0, RC);
    t_bo_reset();
    t_bo_irq();
    t_wdt_por();
    close_out();
  end
endmodule

`default_nettype wire
